// ---- rtl/ssm_map.svh ----
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
// register byte offsets
`define SSM_OFS_CONTROL 8'h00
`define SSM_OFS_TARGET 8'h04
`define SSM_OFS_SECURE 8'h08
`define SSM_OFS_COMMAND 8'h0C
`define SSM_OFS_REF_POS 8'h10
`define SSM_OFS_REF_VEL 8'h14
`define SSM_OFS_STATUS 8'h18
`define SSM_OFS_ACTUAL_POSITION_REGISTER 8'h1C
// control fields
`define SSM_CTL_MODE_LSB 0
`define SSM_CTL_ACC_LSB 4
`define SSM_CTL_VMAX_LSB 8
`define SSM_CTL_VMIN_LSB 12
`define SSM_CTL_RESET 16'h0000
// command opcodes
`define SSM_CMD_GOTO_SAFE 4'h1
`define SSM_CMD_STOP 4'h2
`define SSM_CMD_REF_DRIVE 4'h3
// disabled secure position code (-1024)
`define SSM_SECURE_OFF 11'h400
`define SSM_SECURE_RESET 11'h400
// timing
`define SSM_CLK_MHZ 25
`define SSM_SW_PHASE_US 100
`define SSM_SW_PHASE_CYC (`SSM_SW_PHASE_US * `SSM_CLK_MHZ)
`define SSM_RAMP_UNIT_US 40
`define SSM_RAMP_UNIT_CYC (`SSM_RAMP_UNIT_US * `SSM_CLK_MHZ)
`define SSM_PERIOD_BASE 16'h4000
`define SSM_PERIOD_STEP 16'h0380
`endif

// ---- rtl/ssm_pkg.sv ----
package ssm_pkg;
   typedef enum logic [6:0] {
      ST_INACTIVE = 7'b0000001,
      ST_STOPPED = 7'b0000010,
      ST_MOVE = 7'b0000100,
      ST_REF1 = 7'b0001000,
      ST_REF2 = 7'b0010000,
      ST_SHUT = 7'b0100000,
      ST_DEAD = 7'b1000000
   } ssm_state_e;

   typedef struct packed {
      logic thermal_over;
      logic under_voltage;
      logic electrical_defect;
      logic charge_pump_fail;
   } ssm_fault_s;

   typedef struct packed {
      logic hi_z;
      logic hold_current;
      logic step;
      logic dir;
      logic motor_clk_en;
      logic charge_pump_en;
   } ssm_bridge_s;
endpackage

// ---- rtl/ssm_pace.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssm_map.svh"
// emits one tick every period+1 cycles while run is high
module ssm_pace (
   // system
   input wire logic clock,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic [15:0] period,
   // tick
   output logic tick
);
   logic [15:0] count;
   logic [15:0] next_count;
   logic next_tick;

   always_comb begin
      next_count = count;
      next_tick = 1'b0;
      if (!run) begin
         next_count = 16'h0000;
      end else if (count >= period) begin
         next_count = 16'h0000;
         next_tick = 1'b1;
      end else begin
         next_count = count + 16'h0001;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/ssm_switch.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssm_map.svh"
// alternately sources and sinks; a pin that follows the drive is an open switch
module ssm_switch (
   // system
   input wire logic clock,
   input wire logic rst,
   // pin
   input wire logic switch_sense,
   output logic switch_source,
   // result
   output logic switch_state_flag
);
   localparam logic [15:0] PHASE = 16'(`SSM_SW_PHASE_CYC - 1);
   logic [15:0] count;
   logic [15:0] next_count;
   logic next_source;
   logic next_flag;
   logic miss;
   logic next_miss;

   always_comb begin
      next_count = count + 16'h0001;
      next_source = switch_source;
      next_flag = switch_state_flag;
      next_miss = miss;
      if (count == PHASE) begin
         next_count = 16'h0000;
         next_source = !switch_source;
         next_miss = (switch_sense != switch_source);
         // a pin tied to either rail follows only one of the two phases
         next_flag = (switch_sense != switch_source) || miss;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
         switch_source <= 1'b0;
         switch_state_flag <= 1'b0;
         miss <= 1'b0;
      end else begin
         count <= next_count;
         miss <= next_miss;
         switch_source <= next_source;
         switch_state_flag <= next_flag;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/ssm_supervisor.sv ----
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ssm_map.svh"
// Functional notes
// - positions two's complement, range per stepping mode
// - secure position 11 bits, coarse per mode
// - comm loss or safe command goes secure
// - switch sensed by source/sink, reported in reads
// - switch flag zero while switch open
// - shutdown on thermal, undervoltage, defect, pump
// - shutdown puts bridges in high impedance
// - shutdown copies actual into target position
// - bus keeps answering during shutdown
// - leave shutdown: faults clear plus status read
// - leaving shutdown: hold current, clocks, pump
// - inactive after reset until status read
// - reference command: floor, peak, two targets
// - first motion uses ramp and stored acceleration
// - second motion constant at floor velocity
// - second motion end zeroes actual position
// - then go secure only if enabled
// - reference drive ignores all but stop, shutdown
// - deadlock left by stop then status read
module ssm_supervisor (
   // system
   input wire logic clock,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // monitors
   input wire ssm_pkg::ssm_fault_s faults,
   input wire logic comm_lost,
   // reference switch pin
   input wire logic switch_sense,
   output logic switch_source,
   // bridges
   output ssm_pkg::ssm_bridge_s bridge
);
   ssm_pkg::ssm_state_e state, next_state;
   logic [15:0] actual_position_register, next_actual;
   logic [15:0] target_position_register, next_target;
   logic [15:0] control, next_control;
   logic [10:0] secure, next_secure;
   logic [15:0] ref_pos1, next_ref_pos1;
   logic [15:0] ref_pos2, next_ref_pos2;
   logic [3:0] ref_vmin, next_ref_vmin;
   logic [3:0] ref_vmax, next_ref_vmax;
   logic [3:0] cur_vel, next_cur_vel;
   logic [3:0] top_vel, next_top_vel;
   logic ramp_on, next_ramp_on;
   logic [15:0] ramp_cnt, next_ramp_cnt;
   logic dead_stop, next_dead_stop;
   logic electrical_defect_flag, next_defect_flag;
   logic charge_pump_fail_flag, next_pump_flag;
   logic [31:0] next_readdata;
   logic next_wait;
   ssm_pkg::ssm_bridge_s next_bridge;
   logic [15:0] period;
   logic pace_tick;
   logic switch_state_flag;
   logic rd_go, wr_go, full_status, any_fault, moving, reached;
   logic cmd_wr, cmd_stop, cmd_safe, cmd_ref;
   logic [1:0] mode;
   logic [3:0] acc, vmax, vmin;
   logic [15:0] secure_pos;
   logic secure_en;

   // sign-extend a position to the width of the stepping mode
   function automatic logic [15:0] fit(input logic [15:0] p, input logic [1:0] m);
      logic [15:0] r;
      r = p;
      case (m)
         2'h0: r = {{3{p[12]}}, p[12:0]};
         2'h1: r = {{2{p[13]}}, p[13:0]};
         2'h2: r = {p[14], p[14:0]};
         default: r = p;
      endcase
      return r;
   endfunction

   // start velocity index: vmax scaled by vmin/32, or vmax when vmin is zero
   function automatic logic [3:0] floor_vel(input logic [3:0] vx, input logic [3:0] vn);
      logic [7:0] prod;
      prod = vx * vn;
      if (vn == 4'h0) begin
         return vx;
      end
      return {1'b0, prod[7:5]};
   endfunction

   assign mode = control[`SSM_CTL_MODE_LSB +: 2];
   assign acc = control[`SSM_CTL_ACC_LSB +: 4];
   assign vmax = control[`SSM_CTL_VMAX_LSB +: 4];
   assign vmin = control[`SSM_CTL_VMIN_LSB +: 4];
   // coarse secure position scaled by 4, 8, 16 or 32
   assign secure_pos = fit(16'({{5{secure[10]}}, secure} << (7'd2 + 7'(mode))), mode);
   assign secure_en = (secure != `SSM_SECURE_OFF);
   assign rd_go = avs_read && !avs_waitrequest;
   assign wr_go = avs_write && !avs_waitrequest;
   assign full_status = rd_go && (avs_address == `SSM_OFS_STATUS);
   assign any_fault = faults.thermal_over || faults.under_voltage ||
                      faults.electrical_defect || faults.charge_pump_fail;
   assign cmd_wr = wr_go && (avs_address == `SSM_OFS_COMMAND) && avs_byteenable[0];
   assign cmd_stop = cmd_wr && (avs_writedata[3:0] == `SSM_CMD_STOP);
   assign cmd_safe = cmd_wr && (avs_writedata[3:0] == `SSM_CMD_GOTO_SAFE);
   assign cmd_ref = cmd_wr && (avs_writedata[3:0] == `SSM_CMD_REF_DRIVE);
   assign moving = (state == ssm_pkg::ST_MOVE) || (state == ssm_pkg::ST_REF1) ||
                   (state == ssm_pkg::ST_REF2);
   assign reached = (actual_position_register == target_position_register);
   assign period = `SSM_PERIOD_BASE - 16'(cur_vel * `SSM_PERIOD_STEP);

   ssm_pace u_pace (
      .clock(clock),
      .rst(rst),
      .run(moving && !reached),
      .period(period),
      .tick(pace_tick)
   );

   ssm_switch u_switch (
      .clock(clock),
      .rst(rst),
      .switch_sense(switch_sense),
      .switch_source(switch_source),
      .switch_state_flag(switch_state_flag)
   );

   // bus slave: one wait cycle, answer on the second edge
   always_comb begin
      next_wait = !((avs_read || avs_write) && avs_waitrequest);
      next_readdata = avs_readdata;
      if ((avs_read || avs_write) && avs_waitrequest) begin
         next_readdata = 32'h00000000;
         if (avs_address == `SSM_OFS_CONTROL) begin
            next_readdata = {16'h0000, control};
         end else if (avs_address == `SSM_OFS_TARGET) begin
            next_readdata = {16'h0000, target_position_register};
         end else if (avs_address == `SSM_OFS_SECURE) begin
            next_readdata = {21'h000000, secure};
         end else if (avs_address == `SSM_OFS_REF_POS) begin
            next_readdata = {ref_pos2, ref_pos1};
         end else if (avs_address == `SSM_OFS_REF_VEL) begin
            next_readdata = {24'h000000, ref_vmax, ref_vmin};
         end else if (avs_address == `SSM_OFS_STATUS) begin
            next_readdata = {16'h0000, 1'b0, state, 3'h0, switch_state_flag,
                             electrical_defect_flag, charge_pump_fail_flag,
                             faults.thermal_over, faults.under_voltage};
         end else if (avs_address == `SSM_OFS_ACTUAL_POSITION_REGISTER) begin
            next_readdata = {15'h0000, switch_state_flag, actual_position_register};
         end
      end
   end

   // configuration registers and sticky fault flags
   always_comb begin
      next_control = control;
      next_secure = secure;
      next_ref_pos1 = ref_pos1;
      next_ref_pos2 = ref_pos2;
      next_ref_vmin = ref_vmin;
      next_ref_vmax = ref_vmax;
      if (wr_go && avs_address == `SSM_OFS_CONTROL) begin
         // acceleration is taken as written; the master holds it during motion
         if (avs_byteenable[0]) begin
            next_control[7:0] = avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            next_control[15:8] = avs_writedata[15:8];
         end
      end
      if (wr_go && avs_address == `SSM_OFS_SECURE) begin
         if (avs_byteenable[0]) begin
            next_secure[7:0] = avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            next_secure[10:8] = avs_writedata[10:8];
         end
      end
      if (wr_go && avs_address == `SSM_OFS_REF_POS && state != ssm_pkg::ST_REF1 &&
          state != ssm_pkg::ST_REF2) begin
         if (avs_byteenable[0]) begin
            next_ref_pos1[7:0] = avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            next_ref_pos1[15:8] = avs_writedata[15:8];
         end
         if (avs_byteenable[2]) begin
            next_ref_pos2[7:0] = avs_writedata[23:16];
         end
         if (avs_byteenable[3]) begin
            next_ref_pos2[15:8] = avs_writedata[31:24];
         end
      end
      if (wr_go && avs_address == `SSM_OFS_REF_VEL && avs_byteenable[0] &&
          state != ssm_pkg::ST_REF1 && state != ssm_pkg::ST_REF2) begin
         next_ref_vmin = avs_writedata[3:0];
         next_ref_vmax = avs_writedata[7:4];
      end
      // a new fault wins over the clearing status read
      next_defect_flag = faults.electrical_defect ||
                         (electrical_defect_flag && !full_status);
      next_pump_flag = faults.charge_pump_fail ||
                       (charge_pump_fail_flag && !full_status);
   end

   // motion state machine
   always_comb begin
      next_state = state;
      next_actual = actual_position_register;
      next_target = target_position_register;
      next_cur_vel = cur_vel;
      next_top_vel = top_vel;
      next_ramp_on = ramp_on;
      next_ramp_cnt = ramp_cnt;
      next_dead_stop = dead_stop;
      next_bridge = bridge;
      next_bridge.step = 1'b0;
      if (wr_go && avs_address == `SSM_OFS_TARGET && avs_byteenable[1:0] == 2'h3 &&
          (state == ssm_pkg::ST_STOPPED || state == ssm_pkg::ST_MOVE)) begin
         next_target = fit(avs_writedata[15:0], mode);
         next_cur_vel = floor_vel(vmax, vmin);
         next_top_vel = vmax;
         next_ramp_on = 1'b1;
         next_ramp_cnt = 16'h0000;
         next_state = ssm_pkg::ST_MOVE;
      end
      // stepping toward target with acceleration ramp
      if (moving && pace_tick && !reached) begin
         next_bridge.step = 1'b1;
         next_bridge.dir = ($signed(target_position_register) >
                            $signed(actual_position_register));
         if (next_bridge.dir) begin
            next_actual = fit(actual_position_register + 16'h0001, mode);
         end else begin
            next_actual = fit(actual_position_register - 16'h0001, mode);
         end
      end
      if (moving && ramp_on && cur_vel < top_vel) begin
         if (ramp_cnt >= 16'(({1'b0, ~acc} + 5'h01) * `SSM_RAMP_UNIT_CYC)) begin
            next_ramp_cnt = 16'h0000;
            next_cur_vel = cur_vel + 4'h1;
         end else begin
            next_ramp_cnt = ramp_cnt + 16'h0001;
         end
      end
      case (state)
         ssm_pkg::ST_INACTIVE: begin
            if (full_status) begin
               next_state = ssm_pkg::ST_STOPPED;
            end
         end
         ssm_pkg::ST_STOPPED, ssm_pkg::ST_MOVE: begin
            if (cmd_stop) begin
               next_target = actual_position_register;
               next_state = ssm_pkg::ST_STOPPED;
            end else if (cmd_ref) begin
               if (ref_pos1 == actual_position_register || ref_pos1 == ref_pos2) begin
                  next_state = ssm_pkg::ST_DEAD;
                  next_dead_stop = 1'b0;
               end else begin
                  next_target = fit(ref_pos1, mode);
                  next_cur_vel = floor_vel(ref_vmax, ref_vmin);
                  next_top_vel = ref_vmax;
                  next_ramp_on = 1'b1;
                  next_ramp_cnt = 16'h0000;
                  next_state = ssm_pkg::ST_REF1;
               end
            end else if ((cmd_safe || comm_lost) && secure_en) begin
               next_target = secure_pos;
               next_cur_vel = floor_vel(vmax, vmin);
               next_top_vel = vmax;
               next_ramp_on = 1'b1;
               next_ramp_cnt = 16'h0000;
               next_state = ssm_pkg::ST_MOVE;
            end else if (state == ssm_pkg::ST_MOVE && reached &&
                         next_target == target_position_register) begin
               next_state = ssm_pkg::ST_STOPPED;
            end
         end
         ssm_pkg::ST_REF1: begin
            if (cmd_stop) begin
               next_target = actual_position_register;
               next_state = ssm_pkg::ST_STOPPED;
            end else if (reached) begin
               next_target = fit(ref_pos2, mode);
               next_cur_vel = floor_vel(ref_vmax, ref_vmin);
               next_ramp_on = 1'b0;
               next_state = ssm_pkg::ST_REF2;
            end
         end
         ssm_pkg::ST_REF2: begin
            if (cmd_stop) begin
               next_target = actual_position_register;
               next_state = ssm_pkg::ST_STOPPED;
            end else if (reached) begin
               next_actual = 16'h0000;
               next_state = ssm_pkg::ST_STOPPED;
               next_target = 16'h0000;
               if (secure_en) begin
                  next_target = secure_pos;
                  next_cur_vel = floor_vel(vmax, vmin);
                  next_top_vel = vmax;
                  next_ramp_on = 1'b1;
                  next_ramp_cnt = 16'h0000;
                  next_state = ssm_pkg::ST_MOVE;
               end
            end
         end
         ssm_pkg::ST_SHUT: begin
            if (!any_fault && full_status) begin
               next_state = ssm_pkg::ST_STOPPED;
            end
         end
         ssm_pkg::ST_DEAD: begin
            if (cmd_stop) begin
               next_dead_stop = 1'b1;
            end else if (full_status && dead_stop) begin
               next_state = ssm_pkg::ST_STOPPED;
               next_target = actual_position_register;
            end
         end
         default: begin
            next_state = ssm_pkg::ST_INACTIVE;
         end
      endcase
      // any fault overrides every state, the reference drive included
      if (any_fault && state != ssm_pkg::ST_SHUT) begin
         next_state = ssm_pkg::ST_SHUT;
         next_target = actual_position_register;
         next_bridge.step = 1'b0;
      end
      // bridge drive follows the state being entered
      next_bridge.hi_z = (next_state == ssm_pkg::ST_SHUT) ||
                         (next_state == ssm_pkg::ST_INACTIVE) ||
                         (next_state == ssm_pkg::ST_DEAD);
      next_bridge.hold_current = (next_state == ssm_pkg::ST_STOPPED);
      next_bridge.motor_clk_en = !next_bridge.hi_z;
      next_bridge.charge_pump_en = !next_bridge.hi_z;
      if (next_bridge.hi_z) begin
         next_bridge.step = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ssm_pkg::ST_INACTIVE;
         actual_position_register <= 16'h0000;
         target_position_register <= 16'h0000;
         control <= `SSM_CTL_RESET;
         secure <= `SSM_SECURE_RESET;
         ref_pos1 <= 16'h0000;
         ref_pos2 <= 16'h0000;
         ref_vmin <= 4'h0;
         ref_vmax <= 4'h0;
         cur_vel <= 4'h0;
         top_vel <= 4'h0;
         ramp_on <= 1'b0;
         ramp_cnt <= 16'h0000;
         dead_stop <= 1'b0;
         electrical_defect_flag <= 1'b0;
         charge_pump_fail_flag <= 1'b0;
         avs_readdata <= 32'h00000000;
         avs_waitrequest <= 1'b1;
         bridge <= 6'b100000;
      end else begin
         state <= next_state;
         actual_position_register <= next_actual;
         target_position_register <= next_target;
         control <= next_control;
         secure <= next_secure;
         ref_pos1 <= next_ref_pos1;
         ref_pos2 <= next_ref_pos2;
         ref_vmin <= next_ref_vmin;
         ref_vmax <= next_ref_vmax;
         cur_vel <= next_cur_vel;
         top_vel <= next_top_vel;
         ramp_on <= next_ramp_on;
         ramp_cnt <= next_ramp_cnt;
         dead_stop <= next_dead_stop;
         electrical_defect_flag <= next_defect_flag;
         charge_pump_fail_flag <= next_pump_flag;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_wait;
         bridge <= next_bridge;
      end
   end
endmodule
`default_nettype wire

// ---- tb/ssm_switch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// an open switch lets the pin follow the drive, a closed one ties it to ground
module ssm_switch_model (
   // drive from the device
   input wire logic switch_source,
   // switch position
   input wire logic closed,
   // pin level
   output logic switch_sense
);
   assign switch_sense = closed ? 1'b0 : switch_source;
endmodule
`default_nettype wire

// ---- tb/ssm_supervisor_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssm_map.svh"
module ssm_supervisor_properties (
   // system
   input wire logic clock,
   input wire logic rst,
   // bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pins
   input wire ssm_pkg::ssm_fault_s faults,
   input wire logic switch_source,
   input wire ssm_pkg::ssm_bridge_s bridge
);
   logic [11:0] cnt, next_cnt;
   logic prev_src, rd_seen, next_rd_seen, stat_rd;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   assign stat_rd = avs_read && !avs_waitrequest && avs_address == `SSM_OFS_STATUS;
   // a status read counts only while the bridges float and no fault follows it
   always_comb begin
      next_cnt = (switch_source != prev_src) ? 12'h000 : cnt + 12'h001;
      next_rd_seen = (|faults || !bridge.hi_z) ? 1'b0 : (rd_seen | stat_rd);
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt <= 12'h000;
         prev_src <= 1'b0;
         rd_seen <= 1'b0;
      end else begin
         cnt <= next_cnt;
         prev_src <= switch_source;
         rd_seen <= next_rd_seen;
      end
   end
   fault_shut_a: assert property (|faults |-> ##[1:2] bridge.hi_z)
      else $error("fault did not float the bridges");
   float_quiet_a: assert property (bridge.hi_z |-> !bridge.step && !bridge.charge_pump_en)
      else $error("floating bridges still active");
   leave_read_a: assert property ($fell(bridge.hi_z) |-> rd_seen || stat_rd)
      else $error("bridges enabled without status read");
   leave_hold_a: assert property ($fell(bridge.hi_z) |-> bridge.hold_current &&
      bridge.motor_clk_en && bridge.charge_pump_en)
      else $error("release without holding current");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access not answered");
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   data_stand_a: assert property (!avs_waitrequest |=> $stable(avs_readdata))
      else $error("read data moved");
   switch_phase_a: assert property (switch_source != prev_src |-> cnt >= 12'd2498 && cnt <= 12'd2500)
      else $error("switch phase length wrong");
   cover property (|faults ##2 bridge.hi_z);
   cover property ($fell(bridge.hi_z));
   cover property (bridge.step);
endmodule
bind ssm_supervisor ssm_supervisor_properties u_props (.clock(clock), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .faults(faults),
   .switch_source(switch_source), .bridge(bridge));
`default_nettype wire

// ---- tb/ssm_supervisor_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssm_map.svh"
module ssm_supervisor_bench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rdv;
   logic avs_waitrequest, switch_sense, switch_source;
   logic comm_lost = 1'b0;
   logic sw_closed = 1'b0;
   ssm_pkg::ssm_fault_s faults = '0;
   ssm_pkg::ssm_bridge_s bridge;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [15:0] pos;
   always #20 clock = ~clock;
   ssm_supervisor u_dut (.clock(clock), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .faults(faults), .comm_lost(comm_lost), .switch_sense(switch_sense),
      .switch_source(switch_source), .bridge(bridge));
   ssm_switch_model u_sw (.switch_source(switch_source), .closed(sw_closed),
      .switch_sense(switch_sense));
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_write <= we;
      avs_read <= ~we;
      avs_writedata <= d;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdv = avs_readdata;
      if (n >= 50) chk(1'b0, 1'b1, "no bus answer");
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task st(input logic [6:0] e, input string m);
      rd(`SSM_OFS_STATUS);
      chk(rdv[14:8], e, m);
   endtask
   task pos_wait(input logic [15:0] e);
      int k;
      k = 0;
      do begin
         repeat (100) @(posedge clock);
         rd(`SSM_OFS_ACTUAL_POSITION_REGISTER);
         k++;
      end while (rdv[15:0] !== e && k < 400);
   endtask
   initial begin
      repeat (100000) @(posedge clock);
      n_mismatch++;
      end_sim();
   end
   initial begin
      int i;
      void'($urandom(32'hd458));
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      chk(bridge.hi_z, 1'b1, "bridges float after reset");
      wr(`SSM_OFS_TARGET, 32'h5);
      st(ssm_pkg::ST_INACTIVE, "inactive before status");
      st(ssm_pkg::ST_STOPPED, "stopped after status");
      chk({bridge.hi_z, bridge.hold_current, bridge.motor_clk_en, bridge.charge_pump_en},
         4'b0111, "holding current");
      $display("test power-on done");
      wr(`SSM_OFS_CONTROL, 32'hFFF0);
      wr(`SSM_OFS_SECURE, 32'h7FF);
      comm_lost <= 1'b1;
      @(posedge clock);
      comm_lost <= 1'b0;
      pos_wait(16'hFFFC);
      chk(rdv, 32'h0000FFFC, "secure position, switch open");
      rd(`SSM_OFS_STATUS);
      chk(rdv[4], 1'b0, "switch open in status");
      sw_closed <= 1'b1;
      repeat (5100) @(posedge clock);
      rd(`SSM_OFS_ACTUAL_POSITION_REGISTER);
      chk(rdv[16], 1'b1, "switch closed in position read");
      sw_closed <= 1'b0;
      repeat (5100) @(posedge clock);
      rd(`SSM_OFS_STATUS);
      chk(rdv[4], 1'b0, "switch reopened");
      $display("test secure done");
      for (i = 0; i < 4; i++) begin
         wr(`SSM_OFS_TARGET, {20'h0, 12'($urandom_range(4095, 256))});
         repeat (3000) @(posedge clock);
         faults <= ssm_pkg::ssm_fault_s'(4'h1 << i);
         repeat (3) @(posedge clock);
         chk(bridge.hi_z, 1'b1, "bridges float");
         st(ssm_pkg::ST_SHUT, "shutdown");
         chk(rdv[3:0], {faults.electrical_defect, faults.charge_pump_fail,
            faults.thermal_over, faults.under_voltage}, "fault flags");
         st(ssm_pkg::ST_SHUT, "read with fault keeps shutdown");
         faults <= '0;
         rd(`SSM_OFS_STATUS);
         rd(`SSM_OFS_ACTUAL_POSITION_REGISTER);
         pos = rdv[15:0];
         st(ssm_pkg::ST_STOPPED, "left shutdown");
         rd(`SSM_OFS_TARGET);
         chk(rdv[15:0], pos, "target follows actual");
      end
      $display("test shutdown done");
      wr(`SSM_OFS_REF_VEL, 32'hFF);
      wr(`SSM_OFS_REF_POS, {pos + 16'h1, pos});
      wr(`SSM_OFS_COMMAND, 32'h3);
      st(ssm_pkg::ST_DEAD, "deadlock");
      st(ssm_pkg::ST_DEAD, "read alone keeps deadlock");
      wr(`SSM_OFS_COMMAND, 32'h2);
      rd(`SSM_OFS_STATUS);
      st(ssm_pkg::ST_STOPPED, "deadlock left");
      $display("test deadlock done");
      wr(`SSM_OFS_SECURE, 32'h400);
      wr(`SSM_OFS_REF_POS, {pos, pos + 16'h1});
      wr(`SSM_OFS_COMMAND, 32'h3);
      wr(`SSM_OFS_TARGET, 32'h0800);
      wr(`SSM_OFS_COMMAND, 32'h1);
      st(ssm_pkg::ST_REF1, "first reference motion");
      pos_wait(16'h0);
      chk(rdv[15:0], 16'h0, "zeroed after reference");
      repeat (4000) @(posedge clock);
      rd(`SSM_OFS_ACTUAL_POSITION_REGISTER);
      chk(rdv[15:0], 16'h0, "no move with secure off");
      st(ssm_pkg::ST_STOPPED, "stopped after reference");
      $display("test reference done");
      end_sim();
   end
endmodule
`default_nettype wire
